//--- hw/traffic_cmd_pkg.sv
package traffic_cmd_pkg;

	localparam int NUM_DIR         = 2;
	localparam int DIR_RD          = 0;
	localparam int DIR_WR          = 1;

	localparam int REGION_BYTES    = 4096;
	localparam int CMDS_PER_REGION = 256;
	localparam int WORD_W          = 32;
	localparam int WORDS_PER_CMD   = 4;
	localparam int CMD_W           = WORD_W * WORDS_PER_CMD;
	localparam int IDX_W           = $clog2(CMDS_PER_REGION);
	localparam int WSEL_W          = $clog2(WORDS_PER_CMD);

	// software byte address: region select, command index, word select
	localparam int SW_ADDR_W       = $clog2(REGION_BYTES) + 1;
	localparam int REGION_BIT      = $clog2(REGION_BYTES);
	localparam int IDX_LSB         = $clog2(CMD_W / 8);
	localparam int WSEL_LSB        = $clog2(WORD_W / 8);

	localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(CMDS_PER_REGION - 1);
	localparam logic [IDX_W-1:0] FIRST_IDX = 8'h00;

	// master control register
	localparam int MASTER_ENABLE_BIT = 20;
	localparam logic [WORD_W-1:0] CTRL_RESET = 32'h0000_0000;

	// field positions within the 128-bit command, word 1 starts at bit 32
	localparam int ADDR_LO         = 0;
	localparam int ADDR_W          = 32;
	localparam int W1              = WORD_W;
	localparam int VALID_BIT       = W1 + 31;
	localparam int LB_LO           = W1 + 28;
	localparam int LB_W            = 3;
	localparam int PROT_LO         = W1 + 21;
	localparam int PROT_W          = 3;
	localparam int ID_LO           = W1 + 15;
	localparam int ID_W            = 6;
	localparam int SIZE_LO         = W1 + 12;
	localparam int SIZE_W          = 3;
	localparam int BURST_LO        = W1 + 10;
	localparam int BURST_W         = 2;
	localparam int LOCK_BIT        = W1 + 8;
	localparam int LEN_LO          = W1 + 0;
	localparam int LEN_W           = 8;

	// master port data width and last-beat strobe decoding
	localparam int DATA_W          = 64;
	localparam int STRB_W          = DATA_W / 8;
	localparam logic [LB_W-1:0] LB_ALL    = 3'h0;
	localparam logic [LB_W-1:0] LB64_B0   = 3'h1;
	localparam logic [LB_W-1:0] LB64_B01  = 3'h2;
	localparam logic [LB_W-1:0] LB32_B0   = 3'h4;
	localparam logic [LB_W-1:0] LB32_B01  = 3'h5;
	localparam logic [LB_W-1:0] LB32_B012 = 3'h6;
	localparam logic [STRB_W-1:0] STRB_ALL  = 8'hff;
	localparam logic [STRB_W-1:0] STRB_B0   = 8'h01;
	localparam logic [STRB_W-1:0] STRB_B01  = 8'h03;
	localparam logic [STRB_W-1:0] STRB_B012 = 8'h07;

	typedef enum logic [2:0] {
		S_IDLE,
		S_FETCH,
		S_WAIT,
		S_ISSUE,
		S_DONE
	} fetch_state_t;

	function automatic logic [STRB_W-1:0] last_strobe(
		input logic [LB_W-1:0] code
	);
		logic [STRB_W-1:0] m;
		m = STRB_ALL;
		if (DATA_W == 64)
		begin
			case (code)
				LB64_B0:  m = STRB_B0;
				LB64_B01: m = STRB_B01;
				default:  m = STRB_ALL;
			endcase
		end
		else if (DATA_W == 32)
		begin
			case (code)
				LB32_B0:   m = STRB_B0;
				LB32_B01:  m = STRB_B01;
				LB32_B012: m = STRB_B012;
				default:   m = STRB_ALL;
			endcase
		end
		return m;
	endfunction

endpackage

//--- hw/cmd_memory_bank.sv
// one region: port a for software words, port b fetches whole commands
module cmd_memory_bank (
	input  wire logic                                core_clk,
	input  wire logic                                rst,
	input  wire logic                                a_en,
	input  wire logic                                a_we,
	input  wire logic [traffic_cmd_pkg::IDX_W-1:0]   a_idx,
	input  wire logic [traffic_cmd_pkg::WSEL_W-1:0]  a_wsel,
	input  wire logic [traffic_cmd_pkg::WORD_W-1:0]  a_wdata,
	output logic      [traffic_cmd_pkg::WORD_W-1:0]  a_rdata,
	input  wire logic                                b_en,
	input  wire logic [traffic_cmd_pkg::IDX_W-1:0]   b_idx,
	output logic      [traffic_cmd_pkg::CMD_W-1:0]   b_rdata
);

	typedef struct packed {
		logic [traffic_cmd_pkg::WORD_W-1:0] a_rdata;
		logic [traffic_cmd_pkg::CMD_W-1:0]  b_rdata;
	} bank_state_t;

	bank_state_t s_q;
	bank_state_t s_d;

	logic [traffic_cmd_pkg::CMD_W-1:0] mem [traffic_cmd_pkg::CMDS_PER_REGION];

	always_ff @(posedge core_clk)
	begin
		if (a_en && a_we)
		begin
			mem[a_idx][a_wsel * traffic_cmd_pkg::WORD_W +:
				traffic_cmd_pkg::WORD_W] <= a_wdata;
		end
	end

	always_comb
	begin
		s_d = s_q;
		if (a_en && !a_we)
		begin
			s_d.a_rdata = mem[a_idx][a_wsel * traffic_cmd_pkg::WORD_W +:
				traffic_cmd_pkg::WORD_W];
		end
		if (b_en)
		begin
			s_d.b_rdata = mem[b_idx];
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign a_rdata = s_q.a_rdata;
	assign b_rdata = s_q.b_rdata;

endmodule // cmd_memory_bank

//--- hw/traffic_command_ram_decoder.sv
module traffic_command_ram_decoder (
	input  wire logic                                 core_clk,
	input  wire logic                                 rst,
	input  wire logic                                 sw_req,
	input  wire logic                                 sw_we,
	input  wire logic [traffic_cmd_pkg::SW_ADDR_W-1:0] sw_addr,
	input  wire logic [traffic_cmd_pkg::WORD_W-1:0]   sw_wdata,
	output logic      [traffic_cmd_pkg::WORD_W-1:0]   sw_rdata,
	output logic                                      sw_rvalid,
	output logic                                      sw_blocked,
	input  wire logic                                 ctrl_we,
	input  wire logic [traffic_cmd_pkg::WORD_W-1:0]   ctrl_wdata,
	output logic      [traffic_cmd_pkg::WORD_W-1:0]   ctrl_rdata,
	input  wire logic                                 ar_ready,
	output logic                                      ar_valid,
	output logic      [traffic_cmd_pkg::ADDR_W-1:0]   ar_addr,
	output logic      [traffic_cmd_pkg::PROT_W-1:0]   ar_prot,
	output logic      [traffic_cmd_pkg::ID_W-1:0]     ar_id,
	output logic      [traffic_cmd_pkg::SIZE_W-1:0]   ar_size,
	output logic      [traffic_cmd_pkg::BURST_W-1:0]  ar_burst,
	output logic                                      ar_lock,
	output logic      [traffic_cmd_pkg::LEN_W-1:0]    ar_len,
	input  wire logic                                 aw_ready,
	output logic                                      aw_valid,
	output logic      [traffic_cmd_pkg::ADDR_W-1:0]   aw_addr,
	output logic      [traffic_cmd_pkg::PROT_W-1:0]   aw_prot,
	output logic      [traffic_cmd_pkg::ID_W-1:0]     aw_id,
	output logic      [traffic_cmd_pkg::SIZE_W-1:0]   aw_size,
	output logic      [traffic_cmd_pkg::BURST_W-1:0]  aw_burst,
	output logic                                      aw_lock,
	output logic      [traffic_cmd_pkg::LEN_W-1:0]    aw_len,
	output logic      [traffic_cmd_pkg::STRB_W-1:0]   aw_last_strb,
	output logic                                      rd_halted,
	output logic                                      wr_halted
);

	typedef struct packed {
		logic [traffic_cmd_pkg::WORD_W-1:0]                  ctrl;
		logic                                                sw_rvalid;
		logic                                                sw_blocked;
		logic                                                sw_region;
		traffic_cmd_pkg::fetch_state_t [1:0]                 st;
		logic [1:0][traffic_cmd_pkg::IDX_W-1:0]              idx;
		logic [1:0][traffic_cmd_pkg::CMD_W-1:0]              cmd;
		logic [traffic_cmd_pkg::STRB_W-1:0]                  strb;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic                                        enable;
	logic [1:0]                                  axi_ready;
	logic [1:0]                                  bank_a_en;
	logic [1:0][traffic_cmd_pkg::WORD_W-1:0]     bank_a_rdata;
	logic [1:0][traffic_cmd_pkg::CMD_W-1:0]      bank_b_rdata;

	assign enable    = s_q.ctrl[traffic_cmd_pkg::MASTER_ENABLE_BIT];
	assign axi_ready = {aw_ready, ar_ready};

	// one bank per direction so neither fetch port is ever shared
	for (genvar g = 0; g < traffic_cmd_pkg::NUM_DIR; g++)
	begin : g_bank
		// region picked by address bit 12 only; software blocked when enabled
		assign bank_a_en[g] = sw_req && !enable &&
			(sw_addr[traffic_cmd_pkg::REGION_BIT] == 1'(g));

		cmd_memory_bank u_bank (
			.core_clk (core_clk),
			.rst      (rst),
			.a_en     (bank_a_en[g]),
			.a_we     (sw_we),
			.a_idx    (sw_addr[traffic_cmd_pkg::IDX_LSB +:
				traffic_cmd_pkg::IDX_W]),
			.a_wsel   (sw_addr[traffic_cmd_pkg::WSEL_LSB +:
				traffic_cmd_pkg::WSEL_W]),
			.a_wdata  (sw_wdata),
			.a_rdata  (bank_a_rdata[g]),
			.b_en     (s_q.st[g] == traffic_cmd_pkg::S_FETCH),
			.b_idx    (s_q.idx[g]),
			.b_rdata  (bank_b_rdata[g])
		);
	end

	always_comb
	begin
		s_d = s_q;
		s_d.sw_rvalid  = 1'b0;
		s_d.sw_blocked = 1'b0;
		if (sw_req)
		begin
			if (enable)
			begin
				s_d.sw_blocked = 1'b1;
			end
			else if (!sw_we)
			begin
				s_d.sw_rvalid = 1'b1;
				s_d.sw_region = sw_addr[traffic_cmd_pkg::REGION_BIT];
			end
		end

		// both streams step independently, each on its own ready
		for (int d = 0; d < traffic_cmd_pkg::NUM_DIR; d++)
		begin
			case (s_q.st[d])
				traffic_cmd_pkg::S_IDLE:
				begin
					if (enable)
					begin
						s_d.st[d]  = traffic_cmd_pkg::S_FETCH;
						s_d.idx[d] = traffic_cmd_pkg::FIRST_IDX;
					end
				end
				traffic_cmd_pkg::S_FETCH:
				begin
					s_d.st[d] = traffic_cmd_pkg::S_WAIT;
				end
				traffic_cmd_pkg::S_WAIT:
				begin
					if (bank_b_rdata[d][traffic_cmd_pkg::VALID_BIT])
					begin
						s_d.cmd[d] = bank_b_rdata[d];
						s_d.st[d]  = traffic_cmd_pkg::S_ISSUE;
						if (d == traffic_cmd_pkg::DIR_WR)
						begin
							s_d.strb = traffic_cmd_pkg::last_strobe(
								bank_b_rdata[d][traffic_cmd_pkg::LB_LO +:
								traffic_cmd_pkg::LB_W]);
						end
					end
					else
					begin
						s_d.st[d] = traffic_cmd_pkg::S_DONE;
					end
				end
				traffic_cmd_pkg::S_ISSUE:
				begin
					// request must stay up until accepted, enable or not
					if (axi_ready[d])
					begin
						if (s_q.idx[d] == traffic_cmd_pkg::LAST_IDX)
						begin
							s_d.st[d] = traffic_cmd_pkg::S_DONE;
						end
						else
						begin
							s_d.idx[d] = s_q.idx[d] +
								traffic_cmd_pkg::IDX_W'(1);
							s_d.st[d]  = enable ? traffic_cmd_pkg::S_FETCH :
								traffic_cmd_pkg::S_IDLE;
						end
					end
				end
				traffic_cmd_pkg::S_DONE:
				begin
					if (!enable)
					begin
						s_d.st[d] = traffic_cmd_pkg::S_IDLE;
					end
				end
				default:
				begin
					s_d.st[d] = traffic_cmd_pkg::S_IDLE;
				end
			endcase
		end

		// enable drops once both streams halted; a software write wins
		if (s_q.st[traffic_cmd_pkg::DIR_RD] == traffic_cmd_pkg::S_DONE &&
			s_q.st[traffic_cmd_pkg::DIR_WR] == traffic_cmd_pkg::S_DONE)
		begin
			s_d.ctrl[traffic_cmd_pkg::MASTER_ENABLE_BIT] = 1'b0;
		end
		if (ctrl_we)
		begin
			s_d.ctrl = ctrl_wdata;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s_q      <= '0;
			s_q.ctrl <= traffic_cmd_pkg::CTRL_RESET;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign sw_rdata   = bank_a_rdata[s_q.sw_region];
	assign sw_rvalid  = s_q.sw_rvalid;
	assign sw_blocked = s_q.sw_blocked;
	assign ctrl_rdata = s_q.ctrl;
	assign rd_halted  = s_q.st[traffic_cmd_pkg::DIR_RD] ==
		traffic_cmd_pkg::S_DONE;
	assign wr_halted  = s_q.st[traffic_cmd_pkg::DIR_WR] ==
		traffic_cmd_pkg::S_DONE;

	// fields straight out of the latched command; last-beat strobe from its latched decode
	assign ar_valid = s_q.st[traffic_cmd_pkg::DIR_RD] ==
		traffic_cmd_pkg::S_ISSUE;
	assign ar_addr  = s_q.cmd[traffic_cmd_pkg::DIR_RD][traffic_cmd_pkg::ADDR_LO +:
		traffic_cmd_pkg::ADDR_W];
	assign ar_prot  = s_q.cmd[traffic_cmd_pkg::DIR_RD][traffic_cmd_pkg::PROT_LO +:
		traffic_cmd_pkg::PROT_W];
	assign ar_id    = s_q.cmd[traffic_cmd_pkg::DIR_RD][traffic_cmd_pkg::ID_LO +:
		traffic_cmd_pkg::ID_W];
	assign ar_size  = s_q.cmd[traffic_cmd_pkg::DIR_RD][traffic_cmd_pkg::SIZE_LO +:
		traffic_cmd_pkg::SIZE_W];
	assign ar_burst = s_q.cmd[traffic_cmd_pkg::DIR_RD][traffic_cmd_pkg::BURST_LO +:
		traffic_cmd_pkg::BURST_W];
	assign ar_lock  = s_q.cmd[traffic_cmd_pkg::DIR_RD][
		traffic_cmd_pkg::LOCK_BIT];
	assign ar_len   = s_q.cmd[traffic_cmd_pkg::DIR_RD][traffic_cmd_pkg::LEN_LO +:
		traffic_cmd_pkg::LEN_W];

	assign aw_valid = s_q.st[traffic_cmd_pkg::DIR_WR] ==
		traffic_cmd_pkg::S_ISSUE;
	assign aw_addr  = s_q.cmd[traffic_cmd_pkg::DIR_WR][traffic_cmd_pkg::ADDR_LO +:
		traffic_cmd_pkg::ADDR_W];
	assign aw_prot  = s_q.cmd[traffic_cmd_pkg::DIR_WR][traffic_cmd_pkg::PROT_LO +:
		traffic_cmd_pkg::PROT_W];
	assign aw_id    = s_q.cmd[traffic_cmd_pkg::DIR_WR][traffic_cmd_pkg::ID_LO +:
		traffic_cmd_pkg::ID_W];
	assign aw_size  = s_q.cmd[traffic_cmd_pkg::DIR_WR][traffic_cmd_pkg::SIZE_LO +:
		traffic_cmd_pkg::SIZE_W];
	assign aw_burst = s_q.cmd[traffic_cmd_pkg::DIR_WR][traffic_cmd_pkg::BURST_LO +:
		traffic_cmd_pkg::BURST_W];
	assign aw_lock  = s_q.cmd[traffic_cmd_pkg::DIR_WR][
		traffic_cmd_pkg::LOCK_BIT];
	assign aw_len   = s_q.cmd[traffic_cmd_pkg::DIR_WR][traffic_cmd_pkg::LEN_LO +:
		traffic_cmd_pkg::LEN_W];
	assign aw_last_strb = s_q.strb;

	// fetch-port words, so the decode checks see the raw command
	logic [traffic_cmd_pkg::CMD_W-1:0] rd_word;
	logic [traffic_cmd_pkg::CMD_W-1:0] wr_word;
	logic [traffic_cmd_pkg::IDX_W-1:0] rd_idx;
	logic                              rd_wait;
	logic                              wr_wait;
	logic                              rd_fetch;
	logic                              wr_fetch;

	assign rd_word  = bank_b_rdata[traffic_cmd_pkg::DIR_RD];
	assign wr_word  = bank_b_rdata[traffic_cmd_pkg::DIR_WR];
	assign rd_idx   = s_q.idx[traffic_cmd_pkg::DIR_RD];
	assign rd_wait  = s_q.st[traffic_cmd_pkg::DIR_RD] ==
		traffic_cmd_pkg::S_WAIT;
	assign wr_wait  = s_q.st[traffic_cmd_pkg::DIR_WR] ==
		traffic_cmd_pkg::S_WAIT;
	assign rd_fetch = s_q.st[traffic_cmd_pkg::DIR_RD] ==
		traffic_cmd_pkg::S_FETCH;
	assign wr_fetch = s_q.st[traffic_cmd_pkg::DIR_WR] ==
		traffic_cmd_pkg::S_FETCH;

	sw_block_a: assert property (@(posedge core_clk) disable iff (rst)
		sw_req && enable |-> bank_a_en == 2'h0 ##1 sw_blocked && !sw_rvalid)
		else $error("software reached command memory while enabled");

	sw_read_a: assert property (@(posedge core_clk) disable iff (rst)
		sw_req && !sw_we && !enable |=> sw_rvalid && !sw_blocked)
		else $error("software read of command memory not answered");

	rd_start_a: assert property (@(posedge core_clk) disable iff (rst)
		s_q.st[traffic_cmd_pkg::DIR_RD] == traffic_cmd_pkg::S_IDLE &&
		enable |=> rd_fetch && rd_idx == traffic_cmd_pkg::FIRST_IDX
		##1 rd_wait)
		else $error("read stream did not start at index zero");

	rd_decode_a: assert property (
		@(posedge core_clk) disable iff (rst)
		rd_wait && rd_word[traffic_cmd_pkg::VALID_BIT] |=> ar_valid &&
		ar_addr == $past(rd_word[traffic_cmd_pkg::ADDR_LO +:
			traffic_cmd_pkg::ADDR_W]) &&
		ar_id == $past(rd_word[traffic_cmd_pkg::ID_LO +:
			traffic_cmd_pkg::ID_W]) &&
		ar_prot == $past(rd_word[traffic_cmd_pkg::PROT_LO +:
			traffic_cmd_pkg::PROT_W]) &&
		ar_size == $past(rd_word[traffic_cmd_pkg::SIZE_LO +:
			traffic_cmd_pkg::SIZE_W]) &&
		ar_len == $past(rd_word[traffic_cmd_pkg::LEN_LO +:
			traffic_cmd_pkg::LEN_W]))
		else $error("read request fields differ from command");

	wr_decode_a: assert property (
		@(posedge core_clk) disable iff (rst)
		wr_wait && wr_word[traffic_cmd_pkg::VALID_BIT] |=> aw_valid &&
		aw_burst == $past(wr_word[traffic_cmd_pkg::BURST_LO +:
			traffic_cmd_pkg::BURST_W]) &&
		aw_lock == $past(wr_word[traffic_cmd_pkg::LOCK_BIT]) &&
		aw_last_strb == traffic_cmd_pkg::last_strobe($past(
			wr_word[traffic_cmd_pkg::LB_LO +: traffic_cmd_pkg::LB_W])))
		else $error("write request fields differ from command");

	rd_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		ar_valid && !ar_ready |=> ar_valid && $stable(ar_addr) &&
		$stable(ar_len))
		else $error("read request dropped before acceptance");

	rd_halt_a: assert property (@(posedge core_clk) disable iff (rst)
		rd_wait && !bank_b_rdata[traffic_cmd_pkg::DIR_RD][
		traffic_cmd_pkg::VALID_BIT] |=> rd_halted && !ar_valid ##1 !ar_valid)
		else $error("invalid read command did not halt stream");

	rd_step_a: assert property (@(posedge core_clk) disable iff (rst)
		ar_valid && ar_ready && enable &&
		rd_idx != traffic_cmd_pkg::LAST_IDX |=> rd_fetch &&
		rd_idx == $past(rd_idx) + traffic_cmd_pkg::IDX_W'(1))
		else $error("read index did not advance by one");

	wr_indep_a: assert property (@(posedge core_clk) disable iff (rst)
		ar_valid && !ar_ready && wr_fetch |=> wr_wait ##1 !wr_fetch)
		else $error("write fetch stalled by read stream");

	en_clear_a: assert property (@(posedge core_clk) disable iff (rst)
		rd_halted && wr_halted && !ctrl_we |=>
		!ctrl_rdata[traffic_cmd_pkg::MASTER_ENABLE_BIT])
		else $error("enable not cleared after both streams halted");

endmodule // traffic_command_ram_decoder

//--- bench/axi_addr_slave.sv
// address-channel acceptor; stall sets how long a request is held off
module axi_addr_slave (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic [3:0] stall,
	input  wire logic       valid,
	output logic            ready
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [3:0] wait_q;

	// ready is registered: it never answers in the cycle valid appears
	always_ff @(posedge core_clk)
	begin
		if (rst || (valid && ready))
		begin
			ready  <= 1'b0;
			wait_q <= 4'h0;
		end
		else if (valid && wait_q == stall)
			ready <= 1'b1;
		else if (valid)
			wait_q <= wait_q + 4'h1;
	end
endmodule // axi_addr_slave

//--- bench/traffic_command_ram_decoder_tb.sv
module traffic_command_ram_decoder_tb;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic [31:0] addr;
		logic [2:0]  last, prot;
		logic [5:0]  id;
		logic [2:0]  size;
		logic [1:0]  burst;
		logic        lock;
		logic [7:0]  len, strb;
	} cmd_row_t;

	// fields in, expected last-beat strobes out (64-bit port)
	cmd_row_t rows [4] = '{
		'{32'h1234_5678, 3'h1, 3'h5, 6'h2a, 3'h3, 2'h1, 1'b1, 8'hff, 8'h01},
		'{32'hffff_fffc, 3'h2, 3'h2, 6'h15, 3'h2, 2'h2, 1'b0, 8'h00, 8'h03},
		'{32'h0000_0000, 3'h0, 3'h7, 6'h3f, 3'h7, 2'h0, 1'b1, 8'h0f, 8'hff},
		'{32'ha5a5_0040, 3'h4, 3'h0, 6'h01, 3'h0, 2'h3, 1'b0, 8'h80, 8'hff}
	};

	logic        core_clk, rst, sw_req, sw_we, sw_rvalid, sw_blocked;
	logic [12:0] sw_addr;
	logic [31:0] sw_wdata, sw_rdata, ctrl_wdata, ctrl_rdata, ar_addr, aw_addr;
	logic        ctrl_we, ar_ready, ar_valid, ar_lock, aw_ready, aw_valid;
	logic [2:0]  ar_prot, ar_size, aw_prot, aw_size;
	logic [5:0]  ar_id, aw_id;
	logic [1:0]  ar_burst, aw_burst;
	logic [7:0]  ar_len, aw_len, aw_last_strb;
	logic        aw_lock, rd_halted, wr_halted;
	logic [3:0]  rd_stall, wr_stall;
	int          err_count, n_compared, rd_n, wr_n;
	cmd_row_t    mr, mw;

	traffic_command_ram_decoder dut_u (.*);
	axi_addr_slave rd_slv_u (.core_clk(core_clk), .rst(rst), .stall(rd_stall),
		.valid(ar_valid), .ready(ar_ready));
	axi_addr_slave wr_slv_u (.core_clk(core_clk), .rst(rst), .stall(wr_stall),
		.valid(aw_valid), .ready(aw_ready));

	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic check(input string name, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic sw_acc(input logic we, input logic [12:0] a, logic [31:0] d);
		@(negedge core_clk);
		sw_req = 1'b1;
		sw_we = we;
		sw_addr = a;
		sw_wdata = d;
		@(negedge core_clk);
		sw_req = 1'b0;
	endtask

	task automatic load(input logic rg, logic [7:0] i, cmd_row_t r, logic v);
		sw_acc(1'b1, {rg, i, 4'h0}, r.addr);
		sw_acc(1'b1, {rg, i, 4'h4}, {v, r.last, 4'h0, r.prot, r.id, r.size,
			r.burst, 1'b0, r.lock, r.len});
	endtask

	// address handshakes, compared against the region's table order
	always @(posedge core_clk)
	begin
		if (ar_valid && ar_ready)
		begin
			mr = rows[rd_n[1:0]];
			check("ar_addr", ar_addr, mr.addr);
			check("ar_fields", 32'({ar_prot, ar_id, ar_size, ar_burst, ar_lock,
				ar_len}), 32'({mr.prot, mr.id, mr.size, mr.burst, mr.lock,
				mr.len}));
			rd_n++;
		end
		if (aw_valid && aw_ready)
		begin
			mw = rows[2'd3 - wr_n[1:0]];
			check("aw_addr", aw_addr, mw.addr);
			check("aw_fields", 32'({aw_prot, aw_id, aw_size, aw_burst, aw_lock,
				aw_len}), 32'({mw.prot, mw.id, mw.size, mw.burst, mw.lock,
				mw.len}));
			check("aw_last_strb", 32'(aw_last_strb), 32'(mw.strb));
			wr_n++;
		end
	end

	task automatic run(input int n_rd, n_wr);
		int k;
		rd_n = 0;
		wr_n = 0;
		@(negedge core_clk);
		ctrl_we = 1'b1;
		ctrl_wdata = 32'h0010_0000;
		@(negedge core_clk);
		ctrl_we = 1'b0;
		check("ctrl_rdata", ctrl_rdata, 32'h0010_0000);
		sw_acc(1'b1, 13'h0000, 32'h0bad_0bad);
		check("sw_blocked", 32'(sw_blocked), 32'h1);
		check("sw_rvalid", 32'(sw_rvalid), 32'h0);
		for (k = 0; k < 400 && ctrl_rdata[20]; k++)
			@(negedge core_clk);
		if (k == 400)
		begin
			err_count++;
			$display("ERROR enable_clear expected 0 seen 1");
		end
		else
		begin
			check("rd_halted", 32'(rd_halted), 32'h1);
			check("wr_halted", 32'(wr_halted), 32'h1);
			check("rd_count", rd_n, n_rd);
			check("wr_count", wr_n, n_wr);
		end
	endtask

	initial
	begin
		rst = 1'b1;
		sw_req = 1'b0;
		sw_we = 1'b0;
		sw_addr = 13'h0000;
		sw_wdata = 32'h0000_0000;
		ctrl_we = 1'b0;
		ctrl_wdata = 32'h0000_0000;
		rd_stall = 4'h0;
		wr_stall = 4'h3;
		err_count = 0;
		n_compared = 0;
		rd_n = 0;
		wr_n = 0;
		repeat (12) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		check("ar_valid", 32'(ar_valid), 32'h0);
		check("aw_valid", 32'(aw_valid), 32'h0);
		check("ctrl_rdata", ctrl_rdata, 32'h0000_0000);
		for (int i = 0; i < 4; i++)
		begin
			load(1'b0, 8'(i), rows[i], 1'b1);
			load(1'b1, 8'(i), rows[3 - i], 1'b1);
		end
		// each region ends on an invalid entry
		load(1'b0, 8'h04, rows[0], 1'b0);
		load(1'b1, 8'h04, rows[0], 1'b0);
		sw_acc(1'b1, {1'b0, 8'h02, 4'hc}, 32'h0bad_f00d);
		sw_acc(1'b0, {1'b0, 8'h02, 4'hc}, 32'h0000_0000);
		check("sw_rvalid", 32'(sw_rvalid), 32'h1);
		check("sw_rdata", sw_rdata, 32'h0bad_f00d);
		sw_acc(1'b0, 13'h1000, 32'h0000_0000);
		check("sw_rdata", sw_rdata, rows[3].addr);
		run(4, 4);
		sw_acc(1'b0, 13'h0000, 32'h0000_0000);
		check("sw_rdata", sw_rdata, rows[0].addr);
		// read stream now stops after its first entry, write runs on
		load(1'b0, 8'h01, rows[1], 1'b0);
		rd_stall = 4'h2;
		wr_stall = 4'h0;
		run(1, 4);
		// reset lands while both streams are busy; memory must survive
		rd_n = 0;
		wr_n = 0;
		@(negedge core_clk);
		ctrl_we = 1'b1;
		ctrl_wdata = 32'h0010_0000;
		@(negedge core_clk);
		ctrl_we = 1'b0;
		repeat (5) @(negedge core_clk);
		rst = 1'b1;
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		check("ar_valid", 32'(ar_valid), 32'h0);
		check("aw_valid", 32'(aw_valid), 32'h0);
		check("ctrl_rdata", ctrl_rdata, 32'h0000_0000);
		check("rd_halted", 32'(rd_halted), 32'h0);
		check("wr_halted", 32'(wr_halted), 32'h0);
		check("wr_count", wr_n, 32'h1);
		check("rd_count", rd_n, 32'h0);
		sw_acc(1'b0, 13'h1000, 32'h0000_0000);
		check("sw_rdata", sw_rdata, rows[3].addr);
		report_and_stop;
	end
endmodule // traffic_command_ram_decoder_tb
